// file: testbench.sv
// Self-checking bench for the alternate line mode block.
`timescale 1ns/10ps
module testbench;
	logic sys_clk_i, reset_n_i, ce_i, nack_limit_enable_i, clear_resend_flag_cmd_i;
	logic reset_status_cmd_i, bit_tick_i, os_tick_i, tx_char_load_i, tx_serial_i;
	logic tx_active_i, tx_empty_flag_i, tx_nack_seen_i, tx_ack_seen_i, rx_char_done_i;
	logic rx_parity_i, spi_sck_i, spi_ss_n_i, rxd_tb, go;
	logic [3:0] mode_i;
	logic [2:0] max_iteration_i, repeat_count_o;
	logic [7:0] ir_filter_i, tx_data_i, rx_data_i, pbyte, spi_slave_byte_o;
	logic [4:0] os_div;
	logic txd_o, txd_oe_n_o, rts_o, sck_pin_o, sck_pin_oe_n_o, tx_parity_o, tx_resend_o;
	logic iteration_flag_o, parity_error_flag_o, rx_accept_o, rx_reject_o, rx_serial_o;
	logic spi_slave_select_n_o, spi_slave_byte_valid_o;
	wire logic rxd_i, cts_i, spi_link_sck_i, p_mosi;
	int fail_count, cmp_count;

	// The receive pin carries the peer's MOSI only while the slave mode is chosen.
	assign rxd_i = (mode_i == usalm_pkg::MODE_SPI_SLV) ? p_mosi : rxd_tb;

	usalm_line_modes i_usalm_line_modes (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.ce_i(ce_i), .mode_i(mode_i), .max_iteration_i(max_iteration_i),
		.nack_limit_enable_i(nack_limit_enable_i), .ir_filter_i(ir_filter_i),
		.clear_resend_flag_cmd_i(clear_resend_flag_cmd_i),
		.reset_status_cmd_i(reset_status_cmd_i), .bit_tick_i(bit_tick_i),
		.os_tick_i(os_tick_i), .tx_char_load_i(tx_char_load_i), .tx_data_i(tx_data_i),
		.tx_serial_i(tx_serial_i), .tx_active_i(tx_active_i),
		.tx_empty_flag_i(tx_empty_flag_i), .tx_nack_seen_i(tx_nack_seen_i),
		.tx_ack_seen_i(tx_ack_seen_i), .rx_char_done_i(rx_char_done_i),
		.rx_data_i(rx_data_i), .rx_parity_i(rx_parity_i), .spi_sck_i(spi_sck_i),
		.spi_ss_n_i(spi_ss_n_i), .rxd_i(rxd_i), .cts_i(cts_i),
		.spi_link_sck_i(spi_link_sck_i), .txd_o(txd_o), .txd_oe_n_o(txd_oe_n_o),
		.rts_o(rts_o), .sck_pin_o(sck_pin_o), .sck_pin_oe_n_o(sck_pin_oe_n_o),
		.tx_parity_o(tx_parity_o), .tx_resend_o(tx_resend_o),
		.repeat_count_o(repeat_count_o), .iteration_flag_o(iteration_flag_o),
		.parity_error_flag_o(parity_error_flag_o), .rx_accept_o(rx_accept_o),
		.rx_reject_o(rx_reject_o), .rx_serial_o(rx_serial_o),
		.spi_slave_select_n_o(spi_slave_select_n_o), .spi_slave_byte_o(spi_slave_byte_o),
		.spi_slave_byte_valid_o(spi_slave_byte_valid_o));

	usalm_spi_peer i_usalm_spi_peer (.go_i(go), .byte_i(pbyte), .sck_o(spi_link_sck_i),
		.mosi_o(p_mosi), .ss_n_o(cts_i));

	// ==========================================================
	// Clock and baud ticks
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end

	// Sixteen oversampling ticks, one every two cycles, give a 32 cycle bit time.
	always @(posedge sys_clk_i) begin
		os_div <= os_div + 5'h01;
		os_tick_i <= os_div[0];
		bit_tick_i <= (os_div == 5'h1f);
	end

	// ==========================================================
	// Shared tasks
	task tk;
		@(posedge sys_clk_i);
	endtask

	task chk8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask

	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// A fresh reset per scenario also keeps software's reset duty after mode changes.
	task restart(input logic [3:0] m);
		tk;
		reset_n_i <= 1'b0;
		mode_i <= m;
		tk;
		tk;
		reset_n_i <= 1'b1;
		tk;
	endtask

	// ==========================================================
	// Scenarios
	task sc_resend;
		restart(usalm_pkg::MODE_ISO_T0);
		max_iteration_i <= 3'h2;
		for (int n = 1; n <= 3; n++) begin
			tx_nack_seen_i <= 1'b1;
			tk;
			tx_nack_seen_i <= 1'b0;
			#1;
			chk1(tx_resend_o, n <= 2);
			chk8({5'h00, repeat_count_o}, 8'((n <= 2) ? n : 2));
			chk1(iteration_flag_o, n >= 2);
			tk;
		end
		clear_resend_flag_cmd_i <= 1'b1;
		tk;
		clear_resend_flag_cmd_i <= 1'b0;
		#1;
		chk1(iteration_flag_o, 1'b0);
		tk;
		tx_char_load_i <= 1'b1;
		tk;
		tx_char_load_i <= 1'b0;
		#1;
		chk8({5'h00, repeat_count_o}, 8'h00);
		tk;
		tx_nack_seen_i <= 1'b1;
		tk;
		tx_nack_seen_i <= 1'b0;
		tx_ack_seen_i <= 1'b1;
		#1;
		chk8({5'h00, repeat_count_o}, 8'h01);
		tk;
		tx_ack_seen_i <= 1'b0;
		#1;
		chk8({5'h00, repeat_count_o}, 8'h00);
		tk;
		max_iteration_i <= 3'h0;
		tx_nack_seen_i <= 1'b1;
		tk;
		tx_nack_seen_i <= 1'b0;
		#1;
		chk1(tx_resend_o, 1'b0);
	endtask

	task sc_rx_card;
		restart(usalm_pkg::MODE_ISO_T0);
		max_iteration_i <= 3'h1;
		nack_limit_enable_i <= 1'b1;
		rx_data_i <= 8'h01;
		rx_parity_i <= 1'b0;
		rx_char_done_i <= 1'b1;
		tk;
		rx_char_done_i <= 1'b0;
		#1;
		chk1(rx_reject_o, 1'b1);
		chk1(parity_error_flag_o, 1'b1);
		// The reject pulse arms the NACK driver, and the pin follows a cycle later.
		tk;
		tk;
		#1;
		chk1(txd_o, 1'b0);
		tk;
		rx_char_done_i <= 1'b1;
		tk;
		rx_char_done_i <= 1'b0;
		#1;
		chk1(rx_accept_o, 1'b1);
		chk1(rx_reject_o, 1'b0);
		chk1(iteration_flag_o, 1'b1);
	endtask

	task sc_t1;
		restart(usalm_pkg::MODE_ISO_T1);
		for (int k = 0; k < 2; k++) begin
			tx_data_i <= (k == 0) ? 8'h07 : 8'h03;
			tx_char_load_i <= 1'b1;
			tk;
			tx_char_load_i <= 1'b0;
			#1;
			chk1(tx_parity_o, k == 0);
			tk;
		end
		rx_data_i <= 8'h03;
		rx_parity_i <= 1'b1;
		rx_char_done_i <= 1'b1;
		tk;
		rx_char_done_i <= 1'b0;
		#1;
		chk1(parity_error_flag_o, 1'b1);
		chk1(rx_reject_o, 1'b0);
		tk;
		reset_status_cmd_i <= 1'b1;
		tk;
		reset_status_cmd_i <= 1'b0;
		#1;
		chk1(parity_error_flag_o, 1'b0);
	endtask

	task sc_pins;
		restart(usalm_pkg::MODE_RS485);
		for (int v = 0; v < 2; v++) begin
			tx_empty_flag_i <= v[0];
			tx_serial_i <= v[0];
			tk;
			tk;
			#1;
			chk1(rts_o, !v[0]);
			chk1(txd_o, v[0]);
			tk;
		end
		restart(usalm_pkg::MODE_SPI_MST);
		for (int v = 0; v < 2; v++) begin
			spi_ss_n_i <= v[0];
			spi_sck_i <= !v[0];
			tx_serial_i <= v[0];
			tk;
			tk;
			#1;
			chk1(rts_o, v[0]);
			chk1(sck_pin_o, !v[0]);
			chk1(sck_pin_oe_n_o, 1'b0);
			chk1(txd_o, v[0]);
			tk;
		end
		// Clock enable low must freeze the registered select pin.
		ce_i <= 1'b0;
		spi_ss_n_i <= 1'b0;
		tk;
		tk;
		#1;
		chk1(rts_o, 1'b1);
		tk;
		ce_i <= 1'b1;
	endtask

	task sc_spi_slave;
		int n;
		restart(usalm_pkg::MODE_SPI_SLV);
		tk;
		#1;
		chk1(sck_pin_oe_n_o, 1'b1);
		for (int k = 0; k < 2; k++) begin
			tk;
			pbyte <= (k == 0) ? 8'ha5 : 8'h3c;
			go <= 1'b1;
			repeat (20) tk;
			go <= 1'b0;
			#1;
			chk1(spi_slave_select_n_o, 1'b0);
			chk1(txd_oe_n_o, 1'b0);
			n = 0;
			while (spi_slave_byte_valid_o !== 1'b1 && n < 200) begin
				tk;
				#1;
				n++;
			end
			if (n >= 200) begin
				fail_count++;
				give_verdict;
			end
			chk8(spi_slave_byte_o, pbyte);
			repeat (20) tk;
		end
	endtask

	task sc_irda;
		int n, cnt;
		restart(usalm_pkg::MODE_IRDA);
		// The clock ratio lives outside this block and is taken as nonzero.
		ir_filter_i <= 8'h04;
		tx_active_i <= 1'b1;
		for (int v = 0; v < 2; v++) begin
			tx_serial_i <= v[0];
			repeat (8) tk;
			cnt = 0;
			repeat (64) begin
				tk;
				#1;
				cnt += (txd_o === 1'b1);
			end
			chk8(8'(cnt), (v == 0) ? 8'h0c : 8'h00);
			tk;
		end
		// Only one direction runs at a time on the half-duplex link.
		tx_active_i <= 1'b0;
		rxd_tb <= 1'b0;
		n = 0;
		#1;
		while (rx_serial_o !== 1'b0 && n < 20) begin
			tk;
			#1;
			n++;
		end
		if (n >= 20) begin
			fail_count++;
			give_verdict;
		end
		chk1(n >= 6 && n <= 12, 1'b1);
		tk;
		rxd_tb <= 1'b1;
		repeat (16) tk;
		#1;
		chk1(rx_serial_o, 1'b0);
		repeat (40) tk;
		rxd_tb <= 1'b0;
		repeat (3) tk;
		rxd_tb <= 1'b1;
		cnt = 0;
		repeat (15) begin
			tk;
			#1;
			cnt += (rx_serial_o !== 1'b1);
		end
		chk8(8'(cnt), 8'h00);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		reset_n_i = 1'b0;
		ce_i = 1'b1;
		mode_i = 4'h0;
		{nack_limit_enable_i, clear_resend_flag_cmd_i, reset_status_cmd_i} = 3'h0;
		{tx_char_load_i, tx_active_i, tx_nack_seen_i, tx_ack_seen_i} = 4'h0;
		{rx_char_done_i, rx_parity_i, spi_sck_i, go} = 4'h0;
		{tx_serial_i, tx_empty_flag_i, spi_ss_n_i, rxd_tb} = 4'hf;
		{bit_tick_i, os_tick_i} = 2'h0;
		max_iteration_i = 3'h0;
		{ir_filter_i, tx_data_i, rx_data_i, pbyte} = 32'h0;
		os_div = 5'h00;
		fail_count = 0;
		cmp_count = 0;
		repeat (16) tk;
		reset_n_i <= 1'b1;
		sc_resend;
		sc_rx_card;
		sc_t1;
		sc_pins;
		sc_spi_slave;
		sc_irda;
		give_verdict;
	end
endmodule

// file: usalm_line_modes.sv
// Mode-specific line logic: smart card, infrared, RS485 and SPI pin mapping.
// ==========================================================
`timescale 1ns/10ps
module usalm_line_modes (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [3:0] mode_i,
	input wire logic [2:0] max_iteration_i,
	input wire logic nack_limit_enable_i,
	input wire logic [7:0] ir_filter_i,
	input wire logic clear_resend_flag_cmd_i,
	input wire logic reset_status_cmd_i,
	input wire logic bit_tick_i,
	input wire logic os_tick_i,
	input wire logic tx_char_load_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_serial_i,
	input wire logic tx_active_i,
	input wire logic tx_empty_flag_i,
	input wire logic tx_nack_seen_i,
	input wire logic tx_ack_seen_i,
	input wire logic rx_char_done_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_parity_i,
	input wire logic spi_sck_i,
	input wire logic spi_ss_n_i,
	input wire logic rxd_i,
	input wire logic cts_i,
	input wire logic spi_link_sck_i,
	output logic txd_o,
	output logic txd_oe_n_o,
	output logic rts_o,
	output logic sck_pin_o,
	output logic sck_pin_oe_n_o,
	output logic tx_parity_o,
	output logic tx_resend_o,
	output logic [2:0] repeat_count_o,
	output logic iteration_flag_o,
	output logic parity_error_flag_o,
	output logic rx_accept_o,
	output logic rx_reject_o,
	output logic rx_serial_o,
	output logic spi_slave_select_n_o,
	output logic [7:0] spi_slave_byte_o,
	output logic spi_slave_byte_valid_o
);

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	// ==========================================================
	// Mode decoding

	// True when the mode field selects either smart card protocol.
	function automatic logic is_iso(input logic [3:0] m);
		is_iso = (m == usalm_pkg::MODE_ISO_T0) || (m == usalm_pkg::MODE_ISO_T1);
	endfunction

	logic mode_t0;
	logic mode_iso;
	logic mode_irda;
	logic mode_rs485;
	logic mode_spi_m;
	logic mode_spi_s;

	// Each mode flag is a plain decode of the mode field.
	assign mode_t0 = (mode_i == usalm_pkg::MODE_ISO_T0);
	assign mode_iso = is_iso(mode_i);
	assign mode_irda = (mode_i == usalm_pkg::MODE_IRDA);
	assign mode_rs485 = (mode_i == usalm_pkg::MODE_RS485);
	assign mode_spi_m = (mode_i == usalm_pkg::MODE_SPI_MST);
	assign mode_spi_s = (mode_i == usalm_pkg::MODE_SPI_SLV);

	// ==========================================================
	// Pin synchronisers

	logic rxd_meta;
	logic rxd_sync;
	logic rxd_prev;
	logic cts_meta;
	logic cts_sync;

	// Pins are asynchronous, so two stages precede any use in the system clock domain; only the
	// second stage and later copies feed that logic. The SPI link domain samples rxd_i directly.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rxd_meta <= 1'b1;
			rxd_sync <= 1'b1;
			rxd_prev <= 1'b1;
			cts_meta <= 1'b1;
			cts_sync <= 1'b1;
		end else if (ce_i) begin
			rxd_meta <= rxd_i;
			rxd_sync <= rxd_meta;
			rxd_prev <= rxd_sync;
			cts_meta <= cts_i;
			cts_sync <= cts_meta;
		end
	end

	// ==========================================================
	// Smart card transmit repetition

	logic [2:0] rep_cnt;
	logic tx_nack_ok;
	logic tx_iter_set;

	// A resend is due only while budget remains for this character.
	assign tx_nack_ok = mode_iso && tx_nack_seen_i && (max_iteration_i != 3'h0)
		&& (rep_cnt < max_iteration_i);
	assign tx_iter_set = tx_nack_ok && ((rep_cnt + 3'h1) == max_iteration_i);

	// Counter and resend request; a loaded character restarts the budget.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rep_cnt <= usalm_pkg::ITER_RST;
			tx_resend_o <= 1'b0;
		end else if (ce_i) begin
			tx_resend_o <= tx_nack_ok && !tx_char_load_i;
			if (tx_char_load_i) begin
				rep_cnt <= usalm_pkg::ITER_RST;
			end else if (tx_ack_seen_i) begin
				rep_cnt <= usalm_pkg::ITER_RST;
			end else if (tx_nack_ok) begin
				rep_cnt <= rep_cnt + 3'h1;
			end
		end
	end

	assign repeat_count_o = rep_cnt;

	// Transmit parity is even over the data byte.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_parity_o <= 1'b0;
		end else if (ce_i && tx_char_load_i) begin
			tx_parity_o <= ^tx_data_i;
		end
	end

	// ==========================================================
	// Smart card receive check and NACK limiting

	logic rx_par_bad;
	logic rx_limit_hit;
	logic [2:0] nack_cnt;
	logic nack_drive;

	assign rx_par_bad = rx_char_done_i && mode_iso && ((^rx_data_i) != rx_parity_i);
	assign rx_limit_hit = rx_par_bad && mode_t0 && nack_limit_enable_i
		&& (nack_cnt == max_iteration_i);

	// Good characters and a reached limit are accepted; other T=0 errors
	// are refused with a NACK. T=1 never sends a NACK.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			nack_cnt <= usalm_pkg::ITER_RST;
			rx_accept_o <= 1'b0;
			rx_reject_o <= 1'b0;
		end else if (ce_i) begin
			rx_accept_o <= rx_char_done_i && (!rx_par_bad || rx_limit_hit || !mode_t0);
			rx_reject_o <= rx_par_bad && mode_t0 && !rx_limit_hit;
			if (rx_char_done_i && (!rx_par_bad || rx_limit_hit)) begin
				nack_cnt <= usalm_pkg::ITER_RST;
			end else if (rx_par_bad && mode_t0 && nack_limit_enable_i) begin
				nack_cnt <= nack_cnt + 3'h1;
			end
		end
	end

	// The NACK holds the line low until the next bit boundary.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			nack_drive <= 1'b0;
		end else if (ce_i) begin
			if (rx_reject_o) begin
				nack_drive <= 1'b1;
			end else if (bit_tick_i) begin
				nack_drive <= 1'b0;
			end
		end
	end

	// Sticky flags; a set in the same cycle as a clear wins.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			iteration_flag_o <= 1'b0;
			parity_error_flag_o <= 1'b0;
		end else if (ce_i) begin
			if (tx_iter_set || rx_limit_hit) begin
				iteration_flag_o <= 1'b1;
			end else if (clear_resend_flag_cmd_i) begin
				iteration_flag_o <= 1'b0;
			end
			if (rx_par_bad) begin
				parity_error_flag_o <= 1'b1;
			end else if (reset_status_cmd_i) begin
				parity_error_flag_o <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Infrared modulator

	logic [3:0] ir_os_cnt;
	logic ir_pulse;

	// Oversampling position inside the current transmit bit.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ir_os_cnt <= 4'h0;
		end else if (ce_i) begin
			if (bit_tick_i) begin
				ir_os_cnt <= 4'h0;
			end else if (os_tick_i && (ir_os_cnt != usalm_pkg::OS_LAST)) begin
				ir_os_cnt <= ir_os_cnt + 4'h1;
			end
		end
	end

	// Zero bits light the LED for the first three sixteenths only.
	assign ir_pulse = tx_active_i && !tx_serial_i
		&& (ir_os_cnt <= usalm_pkg::IR_PULSE_LAST);

	// ==========================================================
	// Infrared demodulator

	logic [7:0] filt_cnt;
	logic filt_run;
	logic filt_fire;
	logic low_hold;
	logic [3:0] low_os;

	assign filt_fire = filt_run && (filt_cnt == 8'h00) && rxd_sync == 1'b0;

	// Short glitches reload the counter before it expires, so they never
	// reach the receiver; the filter value sets the shortest pulse seen.
	// The falling edge loads the counter as well, because reset leaves it at
	// zero and the first pulse after reset would otherwise pass unfiltered.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			filt_cnt <= 8'h00;
			filt_run <= 1'b0;
		end else if (ce_i) begin
			if (!mode_irda || (rxd_sync && !rxd_prev)) begin
				filt_cnt <= ir_filter_i;
				filt_run <= 1'b0;
			end else if (!rxd_sync && rxd_prev) begin
				filt_cnt <= ir_filter_i;
				filt_run <= 1'b1;
			end else if (filt_fire) begin
				filt_run <= 1'b0;
				filt_cnt <= ir_filter_i;
			end else if (filt_run) begin
				filt_cnt <= filt_cnt - 8'h01;
			end
		end
	end

	// Receiver input is held low for sixteen oversampling ticks.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			low_hold <= 1'b0;
			low_os <= 4'h0;
		end else if (ce_i) begin
			if (filt_fire) begin
				low_hold <= 1'b1;
				low_os <= 4'h0;
			end else if (low_hold && os_tick_i) begin
				low_os <= low_os + 4'h1;
				low_hold <= (low_os != usalm_pkg::OS_LAST);
			end
		end
	end

	// ==========================================================
	// Pin multiplexing

	// All pin outputs are registered so that mode changes never glitch.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			txd_o <= 1'b1;
			txd_oe_n_o <= 1'b1;
			rts_o <= 1'b0;
			sck_pin_o <= 1'b0;
			sck_pin_oe_n_o <= 1'b1;
			rx_serial_o <= 1'b1;
			spi_slave_select_n_o <= 1'b1;
		end else if (ce_i) begin
			if (mode_irda) begin
				txd_o <= ir_pulse;
			end else begin
				txd_o <= tx_serial_i && !nack_drive;
			end
			if (mode_iso) begin
				txd_oe_n_o <= !(tx_active_i || nack_drive);
			end else if (mode_spi_s) begin
				txd_oe_n_o <= cts_sync;
			end else begin
				txd_oe_n_o <= 1'b0;
			end
			if (mode_rs485) begin
				rts_o <= !tx_empty_flag_i;
			end else if (mode_spi_m) begin
				rts_o <= spi_ss_n_i;
			end else begin
				rts_o <= 1'b0;
			end
			sck_pin_o <= spi_sck_i;
			sck_pin_oe_n_o <= mode_spi_s;
			rx_serial_o <= mode_irda ? !low_hold : rxd_sync;
			spi_slave_select_n_o <= mode_spi_s ? cts_sync : 1'b1;
		end
	end

	// ==========================================================
	// SPI slave link domain

	logic [6:0] lnk_shift;
	logic [2:0] lnk_bits;
	logic [7:0] lnk_byte;
	logic lnk_tog;

	// Runs only while the master clocks; the byte stays stable for eight
	// link edges, far longer than the crossing needs to take it.
	always_ff @(posedge spi_link_sck_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lnk_shift <= 7'h00;
			lnk_bits <= 3'h0;
			lnk_byte <= usalm_pkg::BYTE_RST;
			lnk_tog <= 1'b0;
		end else begin
			lnk_shift <= {lnk_shift[5:0], rxd_i};
			lnk_bits <= lnk_bits + 3'h1;
			if (lnk_bits == usalm_pkg::SPI_BIT_LAST) begin
				lnk_byte <= {lnk_shift, rxd_i};
				lnk_tog <= !lnk_tog;
			end
		end
	end

	logic tog_meta;
	logic tog_sync;
	logic tog_prev;

	// Toggle crossing; the byte is sampled only after the toggle settles.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
			tog_prev <= 1'b0;
			spi_slave_byte_o <= usalm_pkg::BYTE_RST;
			spi_slave_byte_valid_o <= 1'b0;
		end else if (ce_i) begin
			tog_meta <= lnk_tog;
			tog_sync <= tog_meta;
			tog_prev <= tog_sync;
			spi_slave_byte_valid_o <= mode_spi_s && (tog_sync != tog_prev);
			if (tog_sync != tog_prev) begin
				spi_slave_byte_o <= lnk_byte;
			end
		end
	end

	// ==========================================================
	// Assertions

	property p_resend;
		ce_i && tx_nack_ok && !tx_char_load_i && !tx_ack_seen_i
			|=> tx_resend_o && (rep_cnt == $past(rep_cnt) + 3'h1);
	endproperty
	a_resend: assert property (p_resend) else $error("missing resend");

	property p_budget;
		ce_i && mode_iso && tx_nack_seen_i && (rep_cnt == max_iteration_i) |=> !tx_resend_o;
	endproperty
	a_budget: assert property (p_budget) else $error("resend past max");

	property p_iter_set;
		ce_i && tx_iter_set |=> iteration_flag_o;
	endproperty
	a_iter_set: assert property (p_iter_set) else $error("flag not set");

	property p_ack_clr;
		ce_i && tx_ack_seen_i && !tx_char_load_i |=> rep_cnt == 3'h0;
	endproperty
	a_ack_clr: assert property (p_ack_clr) else $error("counter kept");

	property p_flag_clr;
		ce_i && clear_resend_flag_cmd_i && !tx_iter_set && !rx_limit_hit |=> !iteration_flag_o;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

	property p_limit;
		ce_i && rx_limit_hit |=> rx_accept_o && !rx_reject_o && iteration_flag_o;
	endproperty
	a_limit: assert property (p_limit) else $error("limit not honoured");

	property p_par;
		ce_i && rx_par_bad |=> parity_error_flag_o;
	endproperty
	a_par: assert property (p_par) else $error("parity flag missing");

	property p_rs485;
		ce_i && mode_rs485 |=> rts_o == !$past(tx_empty_flag_i);
	endproperty
	a_rs485: assert property (p_rs485) else $error("rts wrong");

	property p_demod;
		ce_i && filt_fire ##1 ce_i |=> !rx_serial_o;
	endproperty
	a_demod: assert property (p_demod) else $error("no low bit");

	property p_spim;
		ce_i && mode_spi_m |=> rts_o == $past(spi_ss_n_i) && !sck_pin_oe_n_o;
	endproperty
	a_spim: assert property (p_spim) else $error("master map wrong");

endmodule

// file: usalm_pkg.sv
// Constants shared by the alternate line mode logic of the serial transceiver.
package usalm_pkg;

	// ==========================================================
	// Operating mode field encodings
	localparam logic [3:0] MODE_RS485 = 4'h1;
	localparam logic [3:0] MODE_ISO_T0 = 4'h4;
	localparam logic [3:0] MODE_ISO_T1 = 4'h5;
	localparam logic [3:0] MODE_IRDA = 4'h8;
	localparam logic [3:0] MODE_SPI_MST = 4'he;
	localparam logic [3:0] MODE_SPI_SLV = 4'hf;

	// ==========================================================
	// Field widths and reset values
	localparam int unsigned ITER_W = 3;
	localparam int unsigned FILT_W = 8;
	localparam logic [2:0] ITER_RST = 3'h0;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// ==========================================================
	// Timing counts in oversampling ticks (sixteen per bit time)
	localparam logic [3:0] OS_LAST = 4'hf;
	localparam logic [3:0] IR_PULSE_LAST = 4'h2;

	// ==========================================================
	// SPI slave character length in link clock edges
	localparam logic [2:0] SPI_BIT_LAST = 3'h7;

endpackage

// file: usalm_spi_peer.sv
// Behavioural SPI master that feeds the slave link of the line mode block.
`timescale 1ns/10ps
module usalm_spi_peer (
	input wire logic go_i,
	input wire logic [7:0] byte_i,
	output logic sck_o,
	output logic mosi_o,
	output logic ss_n_o
);
	// ==========================================================
	// Frame engine
	// SCK stands still between frames and MOSI then shows the inverse of its last bit,
	// so a stale value can never pass for fresh data.
	initial begin
		sck_o = 1'b0;
		mosi_o = 1'b0;
		ss_n_o = 1'b1;
		forever begin
			@(posedge go_i);
			#37 ss_n_o = 1'b0;
			#80;
			for (int i = 7; i >= 0; i--) begin
				mosi_o = byte_i[i];
				#80 sck_o = 1'b1;
				#80 sck_o = 1'b0;
			end
			mosi_o = ~mosi_o;
			#80 ss_n_o = 1'b1;
		end
	end
endmodule
